//--- hdl/converter_regs.svh
// Offsets, field positions and reset values of the converter control register
// Notes on behaviour
// - Five-bit level code in bits 20..16
// - Bit 15 enables voltage generation
// - Bit 8 connects level to pin
// - Source 11 selects analog supply rail
// - Source 01 selects external reference pin
// - Source 10 or 00 forces analog ground
// - Unimplemented bits read zero, ignore writes
// - Clear, set, invert aliases at 4/8/C
`ifndef CONVERTER_REGS_SVH
`define CONVERTER_REGS_SVH
`define CTRL_OFFSET 12'h000
`define CLR_OFFSET 12'h004
`define SET_OFFSET 12'h008
`define INV_OFFSET 12'h00C
`define LEVEL_LSB 16
`define LEVEL_MSB 20
`define ENABLE_BIT 15
`define PIN_BIT 8
`define SRC_LSB 0
`define SRC_MSB 1
`define IMPL_MASK 32'h001F_8103
`define CTRL_RESET 32'h0000_0000
`define SRC_SUPPLY 2'b11
`define SRC_EXTREF 2'b01
`endif

//--- hdl/converter_pkg.sv
// Types shared by the converter control logic
`default_nettype none
package converter_pkg;
  typedef struct packed {
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;
  typedef struct packed {
    logic enable;
    logic pin_drive_enable;
    logic sel_supply;
    logic sel_extref;
    logic force_ground;
    logic [4:0] level_code;
  } ladder_ctl_t;
endpackage
`default_nettype wire

//--- hdl/ladder_decode.sv
// Maps control register contents to analog ladder selects
`timescale 1ns/1ns
`default_nettype none
`include "converter_regs.svh"
module ladder_decode
  import converter_pkg::*;
(
  input wire logic [31:0] ctrl_i,
  output var converter_pkg::ladder_ctl_t ladder_o
);
  wire logic [1:0] src = ctrl_i[`SRC_MSB:`SRC_LSB];
  wire logic on = ctrl_i[`ENABLE_BIT];
  assign ladder_o.enable = on;
  assign ladder_o.pin_drive_enable = on & ctrl_i[`PIN_BIT];
  assign ladder_o.sel_supply = on & (src == `SRC_SUPPLY);
  assign ladder_o.sel_extref = on & (src == `SRC_EXTREF);
  assign ladder_o.force_ground = ~((src == `SRC_SUPPLY) | (src == `SRC_EXTREF)) | ~on;
  // level code, zero gives zero volts
  assign ladder_o.level_code = on ? ctrl_i[`LEVEL_MSB:`LEVEL_LSB] : 5'h0;
endmodule
`default_nettype wire

//--- hdl/converter_ctrl.sv
// APB slave holding the converter control register and ladder outputs
`timescale 1ns/1ns
`default_nettype none
`include "converter_regs.svh"
module converter_ctrl
  import converter_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire converter_pkg::apb_req_t apb_i,
  output var converter_pkg::apb_rsp_t apb_o,
  output var converter_pkg::ladder_ctl_t ladder_o
);
  import converter_pkg::*;

  // ****************************************
  // Transfer phases
  // ****************************************
  // One-hot codes; a stray code falls back to idle
  typedef enum logic [2:0]
  {
    PH_IDLE = 3'b001,
    PH_SETUP = 3'b010,
    PH_ANSWER = 3'b100
  } phase_t;

  // ****************************************
  // Helper functions
  // ****************************************
  // Full compare, so no mirrored words
  function automatic logic addr_hit
  (
    input logic [11:0] addr,
    input logic [11:0] offset
  );
    return addr == offset;
  endfunction

  function automatic logic [31:0] apply_write
  (
    input logic [31:0] cur,
    input logic [31:0] data,
    input logic [3:0] sel
  );
    logic [31:0] result;
    result = cur;
    if (sel[0])
      result = data;
    else if (sel[1])
      result = cur & ~data;
    else if (sel[2])
      result = cur | data;
    else if (sel[3])
      result = cur ^ data;
    return result;
  endfunction

  function automatic logic [31:0] read_view
  (
    input logic [31:0] cur,
    input logic hit
  );
    logic [31:0] view;
    view = 32'h0000_0000;
    if (hit)
      view = cur & `IMPL_MASK;
    return view;
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  phase_t phase_ff;
  phase_t nxt_phase;
  logic [31:0] ctrl_ff;
  logic [31:0] nxt_ctrl;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic err_ff;
  logic nxt_err;
  logic ready_ff;
  logic nxt_ready;
  ladder_ctl_t ladder_ff;
  ladder_ctl_t nxt_ladder;

  // ****************************************
  // Bus decode
  // ****************************************
  wire logic setup = apb_i.psel & ~apb_i.penable;
  wire logic access = apb_i.psel & apb_i.penable;
  wire logic hit_ctrl = addr_hit(apb_i.paddr, `CTRL_OFFSET);
  wire logic hit_clr = addr_hit(apb_i.paddr, `CLR_OFFSET);
  wire logic hit_set = addr_hit(apb_i.paddr, `SET_OFFSET);
  wire logic hit_inv = addr_hit(apb_i.paddr, `INV_OFFSET);
  wire logic [3:0] hit_sel = {hit_inv, hit_set, hit_clr, hit_ctrl};
  wire logic mapped = |hit_sel;
  // One wait state: answer follows the first access cycle
  wire logic first_access = access & ~ready_ff;
  wire logic done = access & ready_ff;
  wire logic wr = done & apb_i.pwrite & mapped;
  wire logic [31:0] wd = apb_i.pwdata & `IMPL_MASK;
  wire logic [31:0] ctrl_view;

  assign nxt_ctrl = apply_write(ctrl_ff, wd, hit_sel);
  // Ladder follows the register in the same edge
  assign ctrl_view = wr ? nxt_ctrl : ctrl_ff;
  assign nxt_ready = (nxt_phase == PH_ANSWER);
  // Unmapped words answer with an error, never hang
  assign nxt_err = nxt_ready & ~mapped;
  assign nxt_rdata = (setup | first_access) ? read_view(ctrl_ff, mapped) : 32'h0000_0000;

  ladder_decode u_decode
  (
    .ctrl_i(ctrl_view),
    .ladder_o(nxt_ladder)
  );

  // ****************************************
  // Phase sequencing
  // ****************************************
  always_comb
  begin
    nxt_phase = PH_IDLE;
    unique case (phase_ff)
      PH_IDLE:
      begin
        if (access)
          nxt_phase = PH_ANSWER;
        else if (setup)
          nxt_phase = PH_SETUP;
        else
          nxt_phase = PH_IDLE;
      end
      PH_SETUP:
      begin
        if (access)
          nxt_phase = PH_ANSWER;
        else if (setup)
          nxt_phase = PH_SETUP;
        else
          nxt_phase = PH_IDLE;
      end
      PH_ANSWER:
      begin
        nxt_phase = PH_IDLE;
      end
      default:
      begin
        nxt_phase = PH_IDLE;
      end
    endcase
  end

  // ****************************************
  // Clocked state
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      phase_ff <= PH_IDLE;
    end
    else
    begin
      phase_ff <= nxt_phase;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ready_ff <= 1'b0;
    end
    else
    begin
      ready_ff <= nxt_ready;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      err_ff <= 1'b0;
    end
    else
    begin
      err_ff <= nxt_err;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_ff <= `CTRL_RESET;
    end
    else if (wr)
    begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ladder_ff <= '0;
    end
    else
    begin
      ladder_ff <= nxt_ladder;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign apb_o.prdata = rdata_ff;
  assign apb_o.pready = ready_ff;
  assign apb_o.pslverr = err_ff;
  assign ladder_o = ladder_ff;
endmodule
`default_nettype wire

//--- tb/converter_monitor.sv
// Port checker for the converter control block
`timescale 1ns/1ns
`default_nettype none
module converter_monitor
  import converter_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire converter_pkg::apb_req_t apb_i,
  input wire converter_pkg::apb_rsp_t apb_o,
  input wire converter_pkg::ladder_ctl_t ladder_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  wire rdy = apb_o.pready;
  wire [31:0] wd = apb_i.pwdata;
  wire wr = apb_i.psel && apb_i.penable && rdy && apb_i.pwrite && apb_i.paddr == 12'h000;
  chk_wait_state: assert property ($rose(apb_i.penable) |=> rdy)
    else $error("late ready");
  chk_rsvd_zero: assert property (rdy |-> (apb_o.prdata & 32'hFFE0_7EFC) == 0)
    else $error("reserved bits set");
  chk_err_map: assert property (rdy |-> apb_o.pslverr == (|apb_i.paddr[11:4] || |apb_i.paddr[1:0]))
    else $error("bad error flag");
  chk_lvl_load: assert property (wr && wd[15] |=> ladder_o.level_code == $past(wd[20:16]))
    else $error("level not loaded");
  chk_en_load: assert property (wr |=> ladder_o.enable == $past(wd[15]))
    else $error("enable not loaded");
  chk_src_rail: assert property (wr && wd[15] |=> ladder_o.sel_supply == $past(&wd[1:0]))
    else $error("rail select wrong");
  chk_src_ext: assert property (wr && wd[15] |=> ladder_o.sel_extref == $past(wd[1:0] == 2'b01))
    else $error("extref select wrong");
  chk_src_ground: assert property (wr |=> ladder_o.force_ground == $past(!wd[15] || !wd[0]))
    else $error("ground wrong");
  chk_pin_gate: assert property (wr |=> ladder_o.pin_drive_enable == $past(wd[15] && wd[8]))
    else $error("pin drive wrong");
endmodule
`default_nettype wire

//--- tb/ladder_model.sv
// Behavioural analog ladder and output pin
`timescale 1ns/1ns
`default_nettype none
module ladder_model
  import converter_pkg::*;
(
  input wire converter_pkg::ladder_ctl_t ctl_i,
  output logic [4:0] pin_o
);
  // Disconnected pin reads as ground level
  assign pin_o = ctl_i.pin_drive_enable && !ctl_i.force_ground ? ctl_i.level_code : 5'h00;
endmodule
`default_nettype wire

//--- tb/control_dac_register_logic_bench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module control_dac_register_logic_bench;
  import converter_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  apb_req_t apb_i = '0;
  apb_rsp_t apb_o;
  ladder_ctl_t ladder_o;
  logic [4:0] pin;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int samples_checked = 0;
  always #2 clk_i = ~clk_i;
  converter_ctrl uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_i(apb_i), .apb_o(apb_o), .ladder_o(ladder_o));
  ladder_model far (.ctl_i(ladder_o), .pin_o(pin));
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Request held until pready is sampled high
  task xfer(input logic [11:0] a, input logic [31:0] d, input logic w);
    @(posedge clk_i);
    apb_i <= '{a, 1'b1, 1'b0, w, d};
    @(posedge clk_i);
    apb_i.penable <= 1'b1;
    do @(posedge clk_i); while (apb_o.pready !== 1'b1);
    rd = apb_o.prdata;
    err = apb_o.pslverr;
    apb_i <= '0;
  endtask
  task step(input logic [11:0] a, input logic [31:0] d, input logic [31:0] e, input logic [4:0] p);
    xfer(a, d, 1'b1);
    xfer(12'h000, 32'h0000_0000, 1'b0);
    chk(rd, e);
    chk({27'h0, pin}, {27'h0, p});
  endtask
  task t_reset;
    xfer(12'h000, 32'h0000_0000, 1'b0);
    chk(rd, 32'h0000_0000);
  endtask
  task t_codes;
    step(12'h000, 32'hFFFF_FFFF, 32'h001F_8103, 5'h1F);
    step(12'h000, 32'h0005_8101, 32'h0005_8101, 5'h05);
    step(12'h000, 32'h0005_8102, 32'h0005_8102, 5'h00);
    step(12'h000, 32'h0005_8100, 32'h0005_8100, 5'h00);
    step(12'h000, 32'h0005_0103, 32'h0005_0103, 5'h00);
  endtask
  task t_alias;
    step(12'h000, 32'h001F_8103, 32'h001F_8103, 5'h1F);
    step(12'h004, 32'h0000_0102, 32'h001F_8001, 5'h00);
    step(12'h008, 32'h0000_0102, 32'h001F_8103, 5'h1F);
    step(12'h00C, 32'h001F_0000, 32'h0000_8103, 5'h00);
    xfer(12'h010, 32'hFFFF_FFFF, 1'b1);
    chk({31'h0, err}, 32'h0000_0001);
    xfer(12'h010, 32'h0000_0000, 1'b0);
    chk(rd, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    xfer(12'h008, 32'h0000_0000, 1'b0);
    chk(rd, 32'h0000_8103);
  endtask
  task t_rerst;
    xfer(12'h000, 32'h001F_8103, 1'b1);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    xfer(12'h000, 32'h0000_0000, 1'b0);
    chk(rd, 32'h0000_0000);
    chk({27'h0, pin}, 32'h0000_0000);
  endtask
  task results;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset;
    t_codes;
    t_alias;
    t_rerst;
    results;
  end
  initial
  begin
    #20000;
    num_errors++;
    results;
  end
endmodule
bind converter_ctrl converter_monitor mon (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_i(apb_i), .apb_o(apb_o), .ladder_o(ladder_o));
`default_nettype wire
